// file: hdl/ecg_lead_off_status_defs.vh
// constants for the electrode lead-off and adc range status block
// assumes a serial interface outside that issues register reads by address
`ifndef ECG_LEAD_OFF_STATUS_DEFS_VH
`define ECG_LEAD_OFF_STATUS_DEFS_VH

`define ELS_ADDR_CONN_STATUS 8'h1D
`define ELS_ADDR_DC_RANGE    8'h1E
`define ELS_RESET_VALUE      24'h000000
`define ELS_BIT_DRV_OFF      23
`define ELS_BIT_LARM_OFF     22
`define ELS_BIT_LLEG_OFF     21
`define ELS_BIT_RARM_OFF     20
`define ELS_BIT_CE_OFF       13
`define ELS_BIT_LARM_ADC     12
`define ELS_BIT_LLEG_ADC     11
`define ELS_BIT_RARM_ADC     10
`define ELS_BIT_DRV_OVER     23
`define ELS_BIT_LARM_OVER    22
`define ELS_BIT_LLEG_OVER    21
`define ELS_BIT_RARM_OVER    20
`define ELS_BIT_CE_OVER      13
`define ELS_BIT_DRV_UNDER    12
`define ELS_BIT_LARM_UNDER   11
`define ELS_BIT_LLEG_UNDER   10
`define ELS_BIT_RARM_UNDER   9
`define ELS_BIT_CE_UNDER     2

`endif

// file: hdl/els_lead_off_status.v
// lead-off and adc range status registers for a five-electrode front end
// assumes comparator/detector flags from analog blocks (async, synchronised
// here), a frame-load pulse and register read port on the same clock
`timescale 1ns/1ps
`include "ecg_lead_off_status_defs.vh"

module els_lead_off_status (
  input  wire        clk,
  input  wire        reset_n,
  input  wire        clkEn,
  input  wire        dcLeadOffEnable,
  input  wire        acLeadOffEnable,
  input  wire [4:0]  dcOverRange,
  input  wire [4:0]  dcUnderRange,
  input  wire [3:0]  acLeadOff,
  input  wire [2:0]  adcOutOfRange,
  input  wire        frameLoad,
  input  wire        regRead,
  input  wire [7:0]  regAddr,
  output reg  [23:0] regReadData,
  output reg         regReadValid,
  output reg  [23:0] frameStatusWord
);

////////////////////////////////////////////////////////////////////////////
// 5-wide buses: 4 leg drive, 3 left arm, 2 left leg, 1 right arm, 0 common
// ac bus: 3 leg drive, 2 left arm, 1 left leg, 0 right arm (no ac on common)
// adc bus: 2 left arm, 1 left leg, 0 right arm

reg  [4:0]  overSync1;
reg  [4:0]  overSync2;
reg  [4:0]  underSync1;
reg  [4:0]  underSync2;
reg  [3:0]  acSync1;
reg  [3:0]  acSync2;
reg  [2:0]  adcSync1;
reg  [2:0]  adcSync2;
reg  [4:0]  electrodeOff;
reg  [2:0]  adcErr;
reg  [4:0]  dcOver;
reg  [4:0]  dcUnder;
reg  [4:0]  eventOff;
wire [4:0]  dcOff;
wire [23:0] connStatus;
wire [23:0] dcRange;

always @(posedge clk or negedge reset_n) begin
  if (!reset_n) begin
    overSync1  <= 5'h00;
    overSync2  <= 5'h00;
    underSync1 <= 5'h00;
    underSync2 <= 5'h00;
    acSync1    <= 4'h0;
    acSync2    <= 4'h0;
    adcSync1   <= 3'h0;
    adcSync2   <= 3'h0;
  end else if (clkEn) begin
    overSync1  <= dcOverRange;
    overSync2  <= overSync1;
    underSync1 <= dcUnderRange;
    underSync2 <= underSync1;
    acSync1    <= acLeadOff;
    acSync2    <= acSync1;
    adcSync1   <= adcOutOfRange;
    adcSync2   <= adcSync1;
  end
end

////////////////////////////////////////////////////////////////////////////
// method select

assign dcOff = overSync2 | underSync2;

always @* begin
  eventOff = 5'h00;
  if (acLeadOffEnable) begin
    eventOff[4:1] = acSync2;
  end else if (dcLeadOffEnable) begin
    eventOff[4:1] = dcOff[4:1];
  end
  // common flag uses dc only, whatever ac does
  eventOff[0] = dcLeadOffEnable & dcOff[0];
end

////////////////////////////////////////////////////////////////////////////
// frame accumulation: a new event in the load cycle seeds the next frame

always @(posedge clk or negedge reset_n) begin
  if (!reset_n) begin
    electrodeOff    <= 5'h00;
    adcErr          <= 3'h0;
    frameStatusWord <= `ELS_RESET_VALUE;
  end else if (clkEn) begin
    if (frameLoad) begin
      frameStatusWord <= connStatus;
      electrodeOff    <= eventOff;
      adcErr          <= adcSync2;
    end else begin
      electrodeOff    <= electrodeOff | eventOff;
      adcErr          <= adcErr | adcSync2;
    end
  end
end

// dc register is live comparator state, gated by dc enable
always @(posedge clk or negedge reset_n) begin
  if (!reset_n) begin
    dcOver  <= 5'h00;
    dcUnder <= 5'h00;
  end else if (clkEn) begin
    dcOver  <= dcLeadOffEnable ? overSync2 : 5'h00;
    dcUnder <= dcLeadOffEnable ? underSync2 : 5'h00;
  end
end

////////////////////////////////////////////////////////////////////////////
// register images; unlisted bits tie to zero

assign connStatus = {electrodeOff[4:1], 6'h00, electrodeOff[0],
                     adcErr, 10'h000};
assign dcRange    = {dcOver[4:1], 6'h00, dcOver[0], dcUnder[4:1],
                     6'h00, dcUnder[0], 2'h0};

// the dc image never enters frameStatusWord, only this read path
always @(posedge clk or negedge reset_n) begin
  if (!reset_n) begin
    regReadData  <= `ELS_RESET_VALUE;
    regReadValid <= 1'b0;
  end else if (clkEn) begin
    regReadValid <= regRead;
    if (regRead) begin
      if (regAddr == `ELS_ADDR_CONN_STATUS) begin
        regReadData <= connStatus;
      end else if (regAddr == `ELS_ADDR_DC_RANGE) begin
        regReadData <= dcRange;
      end else begin
        regReadData <= 24'h000000;
      end
    end
  end
end

endmodule // els_lead_off_status

// file: verif/els_asserts.sv
// checker on the status block ports
// assumes the bind at the foot of this file
`timescale 1ns/1ps
module els_asserts (
  input logic        clk,
  input logic        reset_n,
  input logic        clkEn,
  input logic        frameLoad,
  input logic        regRead,
  input logic [7:0]  regAddr,
  input logic [23:0] regReadData,
  input logic        regReadValid,
  input logic [23:0] frameStatusWord
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire [23:0] d = regReadData, f = frameStatusWord;
  wire a1 = regAddr == 8'h1D, a2 = regAddr == 8'h1E;
  AST_VAL: assert property (regRead && clkEn |=> regReadValid)
    else $error("no valid");
  AST_ONE: assert property (!regRead && clkEn |=> !regReadValid)
    else $error("stray valid");
  AST_RS1: assert property (regRead && a1 |=> !(d & 24'h0FC3FF))
    else $error("rsvd");
  AST_RS2: assert property (regRead && a2 |=> !(d & 24'h0FC1FB))
    else $error("rsvd");
  AST_UNM: assert property (regRead && clkEn && !a1 && !a2 |=> d == 0)
    else $error("unmapped");
  AST_FRS: assert property (!(f & 24'h0FC3FF))
    else $error("rsvd frame");
  AST_FHL: assert property (!frameLoad |=> $stable(f))
    else $error("frame moved");
  AST_DHL: assert property (!regRead |=> $stable(d))
    else $error("data moved");
  cover property (regRead && a2);
  cover property (frameLoad ##1 f != 0);
  cover property (regRead && !a1 && !a2);
endmodule // els_asserts
bind els_lead_off_status els_asserts chk (.*);

// file: verif/els_host_model.sv
// host model: register reads by command
// assumes the answer one cycle after the taking edge
`timescale 1ns/1ps
module els_host_model (
  input  logic        clk,
  input  logic [23:0] regReadData,
  input  logic        regReadValid,
  output logic        regRead = 0,
  output logic [7:0]  regAddr = 0
);
  // address inverted after release so a stale value is never trusted
  task automatic rd(input logic [7:0] a, output logic [23:0] q);
    @(negedge clk) {regRead, regAddr} = {1'h1, a};
    // answer stands for the cycle after the taking edge: take it here
    @(negedge clk) q = regReadValid ? regReadData : 'x;
    {regRead, regAddr} = {1'h0, ~a};
  endtask
endmodule // els_host_model

// file: verif/ecg_lead_off_status_tb.sv
// bench: dc-only and dc+ac lead-off, reads, frame handoff
// assumes host model for reads; flags driven at falling edge
`timescale 1ns/1ps
module ecg_lead_off_status_tb;
  logic        clk = 0, reset_n = 0, clkEn = 1, frameLoad = 0;
  logic        dcLeadOffEnable = 0, acLeadOffEnable = 0;
  logic        regRead, regReadValid;
  logic [4:0]  dcOverRange = 0, dcUnderRange = 0;
  logic [3:0]  acLeadOff = 0;
  logic [2:0]  adcOutOfRange = 0;
  logic [7:0]  regAddr;
  logic [23:0] regReadData, frameStatusWord, q;
  int          miscompares = 0, checks = 0, cyc = 0;
  always #2.5 clk = ~clk;
  els_host_model host (.*);
  els_lead_off_status uut (.*);
  task chk(input logic [23:0] s, e);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %0t got %h want %h", $time, s, e);
    end
  endtask
  task end_sim;
    if (miscompares == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk) if (++cyc == 400) begin
    miscompares++;
    end_sim;
  end
  // two sync edges plus one to accumulate, with margin
  task settle; repeat (4) @(negedge clk); endtask
  task dc_only;
    @(negedge clk) {dcLeadOffEnable, dcOverRange, dcUnderRange,
      adcOutOfRange} = {1'h1, 5'h11, 5'h02, 3'h5};
    settle;
    host.rd(8'h1E, q); chk(q, 24'h802200);
    @(negedge clk) {dcOverRange, dcUnderRange, adcOutOfRange} = 13'h0000;
    settle;
    host.rd(8'h1D, q); chk(q, 24'h903400);
    @(negedge clk) frameLoad = 1'h1;
    @(negedge clk) frameLoad = 1'h0;
    chk(frameStatusWord, 24'h903400);
    host.rd(8'h1D, q); chk(q, 24'h000000);
  endtask
  task ac_both;
    @(negedge clk) {acLeadOffEnable, acLeadOff, dcUnderRange}
      = {1'h1, 4'h4, 5'h03};
    settle;
    host.rd(8'h1D, q); chk(q, 24'h402000);
    host.rd(8'h1E, q); chk(q, 24'h000204);
    host.rd(8'h20, q); chk(q, 24'h000000);
  endtask
  initial begin
    repeat (10) @(negedge clk);
    reset_n = 1'h1;
    dc_only;
    ac_both;
    end_sim;
  end
endmodule // ecg_lead_off_status_tb
